// file: design/spsd_core.v
// SPI port core: registers, FIFOs, status flags, divider and shifter
//
// Design decision made here: the strobed register port.
`include "spsd_defs.vh"

module spsd_core #(
  parameter DEPTH = 4
) (
  input  wire        core_clk,
  input  wire        reset,
  input  wire [31:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        sclk_in,
  output wire        sclk_out,
  output wire        sclk_oe_n,
  input  wire        mosi_in,
  output wire        mosi_out,
  output wire        mosi_oe_n,
  input  wire        miso_in,
  output wire        miso_out,
  output wire        miso_oe_n,
  input  wire        ss_n_in,
  output wire        ss_n_out,
  output wire        ss_n_oe_n
);

  // Threshold field to byte count, one to four
  function [2:0] thr_bytes;
    input [15:0] ctl;
    begin
      thr_bytes = {1'b0, ctl[`SPSD_CTL_THR_HI:`SPSD_CTL_THR_LO]} + 3'd1;
    end
  endfunction

  // Software visible state
  reg [15:0] ctrl_ff;
  reg [5:0]  div_ff;
  reg        ovf_ff;
  reg        rxirq_ff;
  reg        txirq_ff;
  reg        unf_ff;
  reg        sum_ff;

  // FIFO storage and pointers
  reg [7:0]  rx_mem [0:DEPTH-1];
  reg [7:0]  tx_mem [0:DEPTH-1];
  reg [1:0]  rx_wp_ff;
  reg [1:0]  rx_rp_ff;
  reg [2:0]  rx_cnt_ff;
  reg [1:0]  tx_wp_ff;
  reg [1:0]  tx_rp_ff;
  reg [2:0]  tx_cnt_ff;

  // Shifter state
  reg        busy_ff;
  reg        sclk_ff;
  reg        ss_n_ff;
  reg [7:0]  tx_sh_ff;
  reg [6:0]  rx_sh_ff;
  reg [2:0]  bit_ff;
  reg [5:0]  hcnt_ff;
  reg [1:0]  sent_ff;

  // Pin synchronisers, first stage feeds only the second
  reg        sclk_s1_ff;
  reg        sclk_s2_ff;
  reg        sclk_s3_ff;
  reg        mosi_s1_ff;
  reg        mosi_s2_ff;
  reg        miso_s1_ff;
  reg        miso_s2_ff;
  reg        ss_s1_ff;
  reg        ss_s2_ff;
  reg        ss_s3_ff;

  // Decoded control bits
  wire       en      = ctrl_ff[`SPSD_CTL_ENABLE];
  wire       master  = ctrl_ff[`SPSD_CTL_MASTER];
  wire       tx_mode = ctrl_ff[`SPSD_CTL_TXMODE];
  wire       rx_fl   = ctrl_ff[`SPSD_CTL_RXFLUSH];
  wire       tx_fl   = ctrl_ff[`SPSD_CTL_TXFLUSH];
  wire [2:0] thr     = thr_bytes(ctrl_ff);

  // Register access strobes
  wire wr_ctl   = reg_wr && (reg_addr == `SPSD_ADDR_CONTROL);
  wire wr_div   = reg_wr && (reg_addr == `SPSD_ADDR_DIVIDER);
  wire wr_tx    = reg_wr && (reg_addr == `SPSD_ADDR_TXDATA);
  wire rd_rx    = reg_rd && (reg_addr == `SPSD_ADDR_RXDATA);
  wire rd_sta   = reg_rd && (reg_addr == `SPSD_ADDR_STATUS);

  // Slave pin events seen on synchronised levels
  wire s_rise   = sclk_s2_ff && !sclk_s3_ff;
  wire s_fall   = !sclk_s2_ff && sclk_s3_ff;
  wire ss_fall  = !ss_s2_ff && ss_s3_ff;
  wire ss_rise  = ss_s2_ff && !ss_s3_ff;

  // Master half period tick, div+1 cycles per half
  wire m_tick   = busy_ff && master && (hcnt_ff == div_ff);
  wire rise_ev  = master ? (m_tick && !sclk_ff)
                         : (busy_ff && s_rise);
  wire fall_ev  = master ? (m_tick && sclk_ff)
                         : (busy_ff && s_fall);
  // Synchroniser lag: master reads stale bits when div is below 2
  wire din      = master ? miso_s2_ff : mosi_s2_ff;
  wire done_ev  = rise_ev && (bit_ff == 3'd7);

  // Transfer start: master by data or by receive read, slave by select
  wire m_start  = en && master && !busy_ff &&
                  ((tx_mode && tx_cnt_ff != 3'd0 && !tx_fl) ||
                   (!tx_mode && rd_rx));
  wire s_start  = en && !master &&
                  (ss_fall || (done_ev && !ss_s2_ff));
  wire start_ev = m_start || s_start;

  // FIFO movements
  wire tx_empty = (tx_cnt_ff == 3'd0);
  wire tx_pop   = start_ev && !tx_empty && !tx_fl;
  wire tx_push  = wr_tx && !tx_fl && (tx_cnt_ff != DEPTH);
  wire rx_full  = (rx_cnt_ff == DEPTH);
  wire rx_push  = done_ev && !rx_fl && !rx_full;
  wire rx_pop   = rd_rx && (rx_cnt_ff != 3'd0) && !rx_fl;
  wire [7:0] rx_byte = {rx_sh_ff, din};

  // Flag set terms
  wire ovf_set  = done_ev && !rx_fl && rx_full;
  wire unf_set  = start_ev && tx_empty;
  wire rxirq_set = rx_push && !tx_mode &&
                   (rx_cnt_ff + 3'd1 >= thr);
  wire txirq_set = done_ev && tx_mode &&
                   ({1'b0, sent_ff} + 3'd1 == thr);
  wire sum_set  = (ovf_set && !rx_fl) ||
                  (unf_set && !tx_fl) ||
                  rxirq_set || txirq_set;

  wire excess   = rx_cnt_ff > thr;

  // Status word as seen before any clearing
  wire [15:0] status = {4'h0, excess, rx_cnt_ff, ovf_ff, rxirq_ff,
                        txirq_ff, unf_ff, tx_cnt_ff, sum_ff};

  // Pins; enables are low while this end drives
  assign sclk_out  = sclk_ff;
  assign ss_n_out  = ss_n_ff;
  assign mosi_out  = tx_sh_ff[7];
  assign miso_out  = tx_sh_ff[7];
  assign sclk_oe_n = !(en && master);
  assign ss_n_oe_n = !(en && master);
  assign mosi_oe_n = !(en && master);
  assign miso_oe_n = !(en && !master && !ss_s2_ff);

  // Synchronisers for all pins coming from the far end
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      mosi_s1_ff <= 1'b0;
      mosi_s2_ff <= 1'b0;
      miso_s1_ff <= 1'b0;
      miso_s2_ff <= 1'b0;
      ss_s1_ff   <= 1'b1;
      ss_s2_ff   <= 1'b1;
      ss_s3_ff   <= 1'b1;
    end
    else
    begin
      sclk_s1_ff <= sclk_in;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      mosi_s1_ff <= mosi_in;
      mosi_s2_ff <= mosi_s1_ff;
      miso_s1_ff <= miso_in;
      miso_s2_ff <= miso_s1_ff;
      ss_s1_ff   <= ss_n_in;
      ss_s2_ff   <= ss_s1_ff;
      ss_s3_ff   <= ss_s2_ff;
    end
  end

  // Control and divider registers
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      ctrl_ff <= `SPSD_RST_CONTROL;
      div_ff  <= `SPSD_RST_DIVIDER;
    end
    else
    begin
      if (wr_ctl)
        ctrl_ff <= reg_wdata[15:0];
      if (wr_div)
        div_ff <= reg_wdata[5:0];
    end
  end

  // Sticky flags: a set in the same cycle as a status read wins
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      ovf_ff   <= 1'b0;
      rxirq_ff <= 1'b0;
      txirq_ff <= 1'b0;
      unf_ff   <= 1'b0;
      sum_ff   <= 1'b0;
    end
    else
    begin
      ovf_ff   <= (ovf_ff && !rd_sta) || ovf_set;
      rxirq_ff <= (rxirq_ff && !rd_sta) || rxirq_set;
      txirq_ff <= (txirq_ff && !rd_sta) || txirq_set;
      unf_ff   <= (unf_ff && !rd_sta) || unf_set;
      sum_ff   <= (sum_ff && !rd_sta) || sum_set;
    end
  end

  // Receive FIFO; flush holds it empty and drops arrivals
  always @(posedge core_clk)
  begin
    if (reset || rx_fl)
    begin
      rx_wp_ff  <= 2'd0;
      rx_rp_ff  <= 2'd0;
      rx_cnt_ff <= 3'd0;
    end
    else
    begin
      if (rx_push)
      begin
        rx_mem[rx_wp_ff] <= rx_byte;
        rx_wp_ff         <= rx_wp_ff + 2'd1;
      end
      if (rx_pop)
        rx_rp_ff <= rx_rp_ff + 2'd1;
      if (rx_push && !rx_pop)
        rx_cnt_ff <= rx_cnt_ff + 3'd1;
      else if (rx_pop && !rx_push)
        rx_cnt_ff <= rx_cnt_ff - 3'd1;
    end
  end

  // Transmit FIFO; writes are ignored while flushing
  always @(posedge core_clk)
  begin
    if (reset || tx_fl)
    begin
      tx_wp_ff  <= 2'd0;
      tx_rp_ff  <= 2'd0;
      tx_cnt_ff <= 3'd0;
    end
    else
    begin
      if (tx_push)
      begin
        tx_mem[tx_wp_ff] <= reg_wdata[7:0];
        tx_wp_ff         <= tx_wp_ff + 2'd1;
      end
      if (tx_pop)
        tx_rp_ff <= tx_rp_ff + 2'd1;
      if (tx_push && !tx_pop)
        tx_cnt_ff <= tx_cnt_ff + 3'd1;
      else if (tx_pop && !tx_push)
        tx_cnt_ff <= tx_cnt_ff - 3'd1;
    end
  end

  // Shifter, mode 0: sample on rising edge, shift on falling edge
  always @(posedge core_clk)
  begin
    if (reset || !en)
    begin
      busy_ff  <= 1'b0;
      sclk_ff  <= 1'b0;
      ss_n_ff  <= 1'b1;
      tx_sh_ff <= `SPSD_RST_DATA;
      rx_sh_ff <= 7'd0;
      bit_ff   <= 3'd0;
      hcnt_ff  <= 6'd0;
    end
    else if (start_ev)
    begin
      // Empty FIFO sends zero rather than stale data
      busy_ff  <= 1'b1;
      ss_n_ff  <= !master;
      tx_sh_ff <= tx_pop ? tx_mem[tx_rp_ff] : `SPSD_RST_DATA;
      bit_ff   <= 3'd0;
      hcnt_ff  <= 6'd0;
    end
    else if (!master && busy_ff && ss_rise)
    begin
      // Select released mid byte: partial byte is dropped
      busy_ff <= 1'b0;
      bit_ff  <= 3'd0;
    end
    else if (busy_ff)
    begin
      hcnt_ff <= m_tick ? 6'd0 : hcnt_ff + 6'd1;
      if (m_tick)
        sclk_ff <= !sclk_ff;
      if (rise_ev)
      begin
        rx_sh_ff <= rx_byte[6:0];
        bit_ff   <= bit_ff + 3'd1;
      end
      if (fall_ev && bit_ff != 3'd0)
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
      if (master && fall_ev && bit_ff == 3'd0)
      begin
        // Last falling edge closes the master byte
        busy_ff <= 1'b0;
        ss_n_ff <= 1'b1;
      end
    end
  end

  // Bytes sent since the last transmit interrupt
  always @(posedge core_clk)
  begin
    if (reset || !tx_mode)
      sent_ff <= 2'd0;
    else if (txirq_set)
      sent_ff <= 2'd0;
    else if (done_ev)
      sent_ff <= sent_ff + 2'd1;
  end

  // Read data, valid only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    if (reset || !reg_rd)
      reg_rdata <= 32'h00000000;
    else
    begin
      case (reg_addr)
        `SPSD_ADDR_STATUS:
          reg_rdata <= {16'h0000, status};
        `SPSD_ADDR_RXDATA:
          reg_rdata <= (rx_cnt_ff != 3'd0 && !rx_fl)
                       ? {24'h000000, rx_mem[rx_rp_ff]}
                       : 32'h00000000;
        `SPSD_ADDR_CONTROL:
          reg_rdata <= {16'h0000, ctrl_ff};
        default:
          reg_rdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// file: include/spsd_defs.vh
// Register map, field positions, reset values and rule overview for spsd
// Overview of operation
// - Excess flag while receive level exceeds threshold
// - Receive level coded 000 empty to 100
// - Overflow flag when pushing into full FIFO
// - Overflow interrupts unless receive flush set
// - Status read clears all sticky flags
// - Receive irq at threshold in receive-initiate mode
// - Transmit irq after threshold bytes sent
// - Underflow when transfer starts with empty FIFO
// - Underflow interrupts unless transmit flush set
// - Transmit level coded 000 empty to 100
// - Summary flag set by any source, except underflow while transmit flush set
// - Read-only receive data register, resets zero
// - Write-only transmit data register, resets zero
// - Serial clock is clock over 2(1+div)
// - Sixteen-bit control register resets to zero
// - Two-bit field selects one to four bytes
// - Bytes shift MSB first, eight clocks
// - Master drives select low during transfer
// - Receive flush discards bytes, no receive irqs
`ifndef SPSD_DEFS_VH
`define SPSD_DEFS_VH

// Byte addresses of the registers
`define SPSD_ADDR_STATUS  32'hFFFF0A00
`define SPSD_ADDR_RXDATA  32'hFFFF0A04
`define SPSD_ADDR_TXDATA  32'hFFFF0A08
`define SPSD_ADDR_DIVIDER 32'hFFFF0A0C
`define SPSD_ADDR_CONTROL 32'hFFFF0A10

// Reset values
`define SPSD_RST_CONTROL  16'h0000
`define SPSD_RST_DIVIDER  6'h1B
`define SPSD_RST_DATA     8'h00

// Control register fields
`define SPSD_CTL_ENABLE   0
`define SPSD_CTL_MASTER   1
`define SPSD_CTL_TXMODE   6
`define SPSD_CTL_RXFLUSH  12
`define SPSD_CTL_TXFLUSH  13
`define SPSD_CTL_THR_HI   15
`define SPSD_CTL_THR_LO   14

// Status register fields
`define SPSD_STA_EXCESS   11
`define SPSD_STA_RXLVL_HI 10
`define SPSD_STA_RXLVL_LO 8
`define SPSD_STA_OVF      7
`define SPSD_STA_RXIRQ    6
`define SPSD_STA_TXIRQ    5
`define SPSD_STA_UNF      4
`define SPSD_STA_TXLVL_HI 3
`define SPSD_STA_TXLVL_LO 1
`define SPSD_STA_SUMMARY  0

`endif

// file: sim/spsd_core_monitor.sv
// Port checker for the SPI port core
`include "spsd_defs.vh"
module spsd_core_monitor (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        sclk_out,
  input wire logic        ss_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] div_ff;
  logic [1:0] thr_ff;
  logic [6:0] hi_cnt_ff;
  logic       sclk_q_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Shadows of what software wrote; high-phase length counter
  always_ff @(posedge core_clk)
  begin
    sclk_q_ff <= sclk_out;
    hi_cnt_ff <= (sclk_out != sclk_q_ff) ? 7'h00 : hi_cnt_ff + 7'h01;
    if (reset)
    begin
      div_ff <= `SPSD_RST_DIVIDER;
      thr_ff <= 2'h0;
    end
    else if (reg_wr && reg_addr == `SPSD_ADDR_DIVIDER)
      div_ff <= reg_wdata[5:0];
    else if (reg_wr && reg_addr == `SPSD_ADDR_CONTROL)
      thr_ff <= reg_wdata[15:14];
  end
  sequence sta_rd;
    reg_rd && reg_addr == `SPSD_ADDR_STATUS;
  endsequence
  sequence ctl_wr_rd;
    reg_wr && reg_addr == `SPSD_ADDR_CONTROL ##1
    reg_rd && reg_addr == `SPSD_ADDR_CONTROL;
  endsequence
  status_clear_a: assert property (
    sta_rd ##1 (sta_rd and ss_n_out) ##1 ss_n_out |->
    reg_rdata[7:4] == 4'h0 && !reg_rdata[0])
    else $error("sticky flags survived a status read");
  rx_excess_a: assert property (sta_rd |=>
    reg_rdata[11] == (reg_rdata[10:8] > {1'b0, thr_ff} + 3'h1))
    else $error("excess flag disagrees with level");
  summary_set_a: assert property (sta_rd |=>
    !(reg_rdata[6] || reg_rdata[5]) || reg_rdata[0])
    else $error("irq flag without summary flag");
  div_half_a: assert property ($fell(sclk_out) |->
    hi_cnt_ff == {1'b0, div_ff})
    else $error("serial clock high phase wrong length");
  frame_end_a: assert property ($rose(ss_n_out) |-> $fell(sclk_out))
    else $error("select released off the last clock edge");
  sclk_idle_a: assert property (ss_n_out |-> !sclk_out)
    else $error("serial clock high while deselected");
  wo_read_a: assert property (reg_rd &&
    (reg_addr == `SPSD_ADDR_TXDATA || reg_addr == `SPSD_ADDR_DIVIDER)
    |=> reg_rdata == 32'h0)
    else $error("write-only register read back data");
  ctl_back_a: assert property (ctl_wr_rd |=>
    reg_rdata[15:0] == $past(reg_wdata[15:0], 2))
    else $error("control register read back wrong");
endmodule
bind spsd_core spsd_core_monitor u_mon (.core_clk, .reset, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sclk_out, .ss_n_out);

// file: sim/spsd_core_tb_top.sv
// Self-checking bench for the SPI port core
`include "spsd_defs.vh"
module spsd_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_q = 1'b0;
  logic        m_sclk = 1'b0;
  logic        m_mosi = 1'b0;
  logic        m_ss_n = 1'b1;
  logic [7:0]  tx_s;
  logic [7:0]  rx_s;
  logic [7:0]  got_s;
  logic [31:0] exp_q[$];
  logic [7:0]  tx_b[5];
  logic [5:0]  div;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          seed = 7;
  int          i;
  int          t;
  wire  [31:0] reg_rdata;
  wire         sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_out;
  wire         miso_oe_n, ss_n_out, ss_n_oe_n, slv_miso;
  // Far master, or the slave model on miso, drives when the core does not; idle levels match the pulls
  wire         sclk_w = sclk_oe_n ? m_sclk : sclk_out;
  wire         mosi_w = mosi_oe_n ? m_mosi : mosi_out;
  wire         ss_w = ss_n_oe_n ? m_ss_n : ss_n_out;
  wire         miso_w = miso_oe_n ? slv_miso : miso_out;

  spsd_core DUT (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sclk_in(sclk_w), .sclk_out, .sclk_oe_n, .mosi_in(mosi_w),
    .mosi_out, .mosi_oe_n, .miso_in(miso_w), .miso_out, .miso_oe_n,
    .ss_n_in(ss_w), .ss_n_out, .ss_n_oe_n);
  spsd_spi_slave u_slv (.sclk(sclk_w), .ss_n(ss_w), .mosi(mosi_w),
    .miso(slv_miso));

  always #4 core_clk = ~core_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Bus cycles: strobes stay one cycle, lowered by the next call
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    if (!w)
      exp_q.push_back(d);
  endtask

  // Drop strobes, then wait for n whole frames, each bounded
  task automatic frames(input int n);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n)
    begin
      for (t = 0; ss_n_out !== 1'b0 && t < 60; t++)
        @(posedge core_clk);
      for (t = 0; ss_n_out !== 1'b1 && t < 3000; t++)
        @(posedge core_clk);
    end
  endtask

  // Far master for slave mode: mode 0, five core cycles per half period
  task automatic slave_byte(input logic [7:0] mb, output logic [7:0] sb);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    m_ss_n <= 1'b0;
    m_mosi <= mb[7];
    for (int b = 7; b >= 0; b--)
    begin
      repeat (5) @(posedge core_clk);
      m_sclk <= 1'b1;
      sb[b] = miso_w;
      repeat (5) @(posedge core_clk);
      m_sclk <= 1'b0;
      m_mosi <= (b > 0) ? mb[b - 1] : 1'b0;
    end
    repeat (5) @(posedge core_clk);
    m_ss_n <= 1'b1;
    repeat (5) @(posedge core_clk);
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    if (rd_q)
      check(reg_rdata, exp_q.pop_front());
    rd_q <= reg_rd;
  end

  initial
  begin
    #100us;
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    // Divider from 2 up: the receive synchroniser needs the slack
    div = (6'($random(seed)) & 6'h03) + 6'h02;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    bus(0, `SPSD_ADDR_CONTROL, 32'h0);
    bus(0, `SPSD_ADDR_RXDATA, 32'h0);
    bus(0, `SPSD_ADDR_STATUS, 32'h0);
    bus(0, `SPSD_ADDR_TXDATA, 32'h0);
    bus(0, 32'hFFFF0A14, 32'h0);
    bus(1, `SPSD_ADDR_DIVIDER, {26'h0, div});
    bus(1, `SPSD_ADDR_CONTROL, 32'h4042);
    bus(0, `SPSD_ADDR_CONTROL, 32'h4042);
    // Fill the transmit FIFO while disabled; the fifth write is refused
    for (i = 0; i < 5; i++)
    begin
      tx_b[i] = 8'($random(seed));
      bus(1, `SPSD_ADDR_TXDATA, {24'h0, tx_b[i]});
    end
    bus(0, `SPSD_ADDR_STATUS, 32'h0008);
    bus(1, `SPSD_ADDR_CONTROL, 32'h4043);
    frames(4);
    bus(1, `SPSD_ADDR_TXDATA, {24'h0, tx_b[4]});
    frames(1);
    // Fifth byte lands on a full receive FIFO
    bus(0, `SPSD_ADDR_STATUS, 32'h0CA1);
    bus(0, `SPSD_ADDR_STATUS, 32'h0C00);
    // Receive-initiate mode: each read pops and starts an empty transfer
    bus(1, `SPSD_ADDR_CONTROL, 32'h0003);
    for (i = 0; i < 4; i++)
    begin
      bus(0, `SPSD_ADDR_RXDATA, 32'hA0 + i);
      frames(1);
    end
    bus(0, `SPSD_ADDR_STATUS, 32'h0C51);
    // Both flushes: bytes dropped, underflow without summary
    bus(1, `SPSD_ADDR_CONTROL, 32'h3003);
    bus(0, `SPSD_ADDR_RXDATA, 32'h0);
    frames(1);
    bus(0, `SPSD_ADDR_STATUS, 32'h0010);
    // Slave mode: the bench plays the far master on the pins
    bus(1, `SPSD_ADDR_CONTROL, 32'h0001);
    tx_s = 8'($random(seed));
    rx_s = 8'($random(seed));
    bus(1, `SPSD_ADDR_TXDATA, {24'h0, tx_s});
    slave_byte(rx_s, got_s);
    check({24'h0, got_s}, {24'h0, tx_s});
    // Select held past the byte restarts on an empty FIFO
    bus(0, `SPSD_ADDR_STATUS, 32'h0151);
    bus(0, `SPSD_ADDR_RXDATA, {24'h0, rx_s});
    frames(0);
    repeat (2) @(posedge core_clk);
    for (i = 0; i < 10; i++)
      check(u_slv.got_q[i], i < 5 ? tx_b[i] : 8'h00);
    report_and_stop();
  end
endmodule

// file: sim/spsd_spi_slave.sv
// Behavioural mode-0 SPI slave facing the core in master mode
module spsd_spi_slave (
  input  wire logic sclk,
  input  wire logic ss_n,
  input  wire logic mosi,
  output wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx_sh = 8'h00;
  logic [7:0] rx_sh;
  logic [7:0] got_q[$];
  int         nb;
  int         k = 0;
  // Reply to frame k is A0+k so the bench can predict it
  always @(negedge ss_n)
  begin
    tx_sh = 8'hA0 + 8'(k);
    k = k + 1;
    nb = 0;
  end
  // Sample on rising edge; a partial byte never reaches the queue
  always @(posedge sclk)
    if (!ss_n)
    begin
      rx_sh = {rx_sh[6:0], mosi};
      nb = nb + 1;
      if (nb == 8)
        got_q.push_back(rx_sh);
    end
  // Shift MSB first on falling edge
  always @(negedge sclk)
    if (!ss_n)
      tx_sh = tx_sh << 1;
  // Deselected: inverse of last bit, so stale data cannot pass
  assign miso = tx_sh[7] ^ ss_n;
endmodule
